// file: shared/csseq_pkg.sv
package csseq_pkg;
  // ------------------------------------------------------------
  // Clock and oscillator rates
  // ------------------------------------------------------------
  localparam int CLK_KHZ = 100000;
  localparam int OSC_R0_KHZ = 1500;
  localparam int OSC_R1_KHZ = 3000;
  localparam int OSC_R2_KHZ = 6000;
  localparam int OSC_R3_KHZ = 12000;
  localparam int OSC_R4_KHZ = 25000;
  localparam int OSC_R5_KHZ = 50000;
  // Longest whole period that does not exceed the nominal period, so never below the rate
  localparam logic [6:0] OSC_R0_DIV = 7'(CLK_KHZ / OSC_R0_KHZ);
  localparam logic [6:0] OSC_R1_DIV = 7'(CLK_KHZ / OSC_R1_KHZ);
  localparam logic [6:0] OSC_R2_DIV = 7'(CLK_KHZ / OSC_R2_KHZ);
  localparam logic [6:0] OSC_R3_DIV = 7'(CLK_KHZ / OSC_R3_KHZ);
  localparam logic [6:0] OSC_R4_DIV = 7'(CLK_KHZ / OSC_R4_KHZ);
  localparam logic [6:0] OSC_R5_DIV = 7'(CLK_KHZ / OSC_R5_KHZ);
  localparam logic [2:0] RATE_SLOWEST = 3'h0;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] OPT_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] LOCKMASK_OFS = 8'h0c;
  localparam int OPT_RATE_LSB = 0;
  localparam int OPT_CLKSEL_LSB = 3;
  localparam int OPT_EXTCFG_BIT = 5;
  localparam int OPT_DONESEL_LSB = 6;
  localparam int OPT_GWESEL_LSB = 9;
  localparam int OPT_GTSSEL_LSB = 12;
  localparam int OPT_LCKSEL_LSB = 15;
  localparam int OPT_DRIVE_BIT = 18;
  localparam int OPT_PIPE_BIT = 19;
  localparam int CTRL_LOAD_BIT = 0;
  localparam int CTRL_RELOAD_BIT = 1;
  localparam int N_LOCK = 4;
  localparam logic [3:0] LOCKMASK_RST = 4'h0;

  // ------------------------------------------------------------
  // Option codes and reset values
  // ------------------------------------------------------------
  localparam logic [1:0] CLKSEL_CFG = 2'h0;
  localparam logic [1:0] CLKSEL_FAB = 2'h1;
  localparam logic [1:0] CLKSEL_TCK = 2'h2;
  localparam logic [2:0] SEL_DONE = 3'h0;
  localparam logic [2:0] SEL_KEEP = 3'h7;
  localparam logic [2:0] LCK_NO_LOCK_WAIT = 3'h7;
  localparam logic [2:0] DONESEL_RST = 3'h4;
  localparam logic [2:0] GWESEL_RST = 3'h6;
  localparam logic [2:0] GTSSEL_RST = 3'h5;
  localparam logic [2:0] PHASE_LAST = 3'h7;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_STARTUP = 2'b01,
    ST_USER = 2'b10
  } csseq_state_t;
endpackage

// file: shared/csseq_tick_if.sv
`timescale 1ns/100ps
interface csseq_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

// file: hw/csseq_edge_det.sv
`timescale 1ns/100ps
module csseq_edge_det (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic level,
  csseq_tick_if.src rise
);
  logic prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level;
    end
  end

  assign rise.tick = level & ~prev_q;
endmodule

// file: hw/csseq_osc_div.sv
`timescale 1ns/100ps
module csseq_osc_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [6:0] div,
  csseq_tick_if.src osc
);
  logic [6:0] cnt_q;
  logic tick_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 7'h00;
      tick_q <= 1'b0;
    end else if (cnt_q >= div - 7'h01) begin
      cnt_q <= 7'h00;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 7'h01;
      tick_q <= 1'b0;
    end
  end

  assign osc.tick = tick_q;
endmodule

// file: hw/csseq_top.sv
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/100ps
module csseq_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic config_clock_in,
  input wire logic fabric_clock_in,
  input wire logic tck_in,
  input wire logic [3:0] clock_manager_lock,
  input wire logic done_in,
  output logic done_out,
  output logic done_oe,
  output logic config_clock_tick,
  output logic global_write_enable,
  output logic global_tristate,
  output logic global_set_reset
);
  // ------------------------------------------------------------
  // Registers and options
  // ------------------------------------------------------------
  logic [19:0] opt_q;
  logic [3:0] lockmask_q;
  logic [31:0] prdata_q;
  logic [2:0] rate_active_q;
  logic [2:0] gwe_sel_q;
  logic [2:0] gts_sel_q;
  logic [2:0] phase_q;
  logic [2:0] phase_d;
  logic gwe_q;
  logic gts_q;
  logic gsr_q;
  logic done_act_q;
  logic done_pipe_q;
  logic lock_ok;
  logic done_eff;
  csseq_pkg::csseq_state_t state_q;

  logic wr_en;
  logic rd_en;
  logic mapped;
  logic load_pulse;
  logic reload_pulse;
  logic [2:0] opt_rate;
  logic [1:0] opt_clksel;
  logic [2:0] opt_donesel;
  logic [2:0] opt_gwesel;
  logic [2:0] opt_gtssel;
  logic [2:0] opt_lcksel;
  logic opt_drive;
  logic opt_pipe;
  logic opt_extcfg;

  assign opt_rate = opt_q[csseq_pkg::OPT_RATE_LSB +: 3];
  assign opt_clksel = opt_q[csseq_pkg::OPT_CLKSEL_LSB +: 2];
  assign opt_extcfg = opt_q[csseq_pkg::OPT_EXTCFG_BIT];
  assign opt_donesel = opt_q[csseq_pkg::OPT_DONESEL_LSB +: 3];
  assign opt_gwesel = opt_q[csseq_pkg::OPT_GWESEL_LSB +: 3];
  assign opt_gtssel = opt_q[csseq_pkg::OPT_GTSSEL_LSB +: 3];
  assign opt_lcksel = opt_q[csseq_pkg::OPT_LCKSEL_LSB +: 3];
  assign opt_drive = opt_q[csseq_pkg::OPT_DRIVE_BIT];
  assign opt_pipe = opt_q[csseq_pkg::OPT_PIPE_BIT];

  // ------------------------------------------------------------
  // APB slave, zero wait states
  // ------------------------------------------------------------
  assign mapped = (paddr == csseq_pkg::OPT_OFS) || (paddr == csseq_pkg::CTRL_OFS)
                  || (paddr == csseq_pkg::STAT_OFS) || (paddr == csseq_pkg::LOCKMASK_OFS);
  assign wr_en = psel & penable & pwrite & mapped;
  assign rd_en = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_q;
  assign load_pulse = wr_en && (paddr == csseq_pkg::CTRL_OFS)
                      && pwdata[csseq_pkg::CTRL_LOAD_BIT];
  assign reload_pulse = wr_en && (paddr == csseq_pkg::CTRL_OFS)
                        && pwdata[csseq_pkg::CTRL_RELOAD_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_q <= {1'b0, 1'b0, csseq_pkg::LCK_NO_LOCK_WAIT, csseq_pkg::GTSSEL_RST,
                csseq_pkg::GWESEL_RST, csseq_pkg::DONESEL_RST, 1'b0,
                csseq_pkg::CLKSEL_CFG, csseq_pkg::RATE_SLOWEST};
      lockmask_q <= csseq_pkg::LOCKMASK_RST;
    end else if (wr_en && paddr == csseq_pkg::OPT_OFS) begin
      opt_q <= pwdata[19:0];
    end else if (wr_en && paddr == csseq_pkg::LOCKMASK_OFS) begin
      lockmask_q <= pwdata[3:0];
    end
  end

  // Read data captured in the setup cycle so it is stable in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        csseq_pkg::OPT_OFS: prdata_q <= {12'h000, opt_q};
        csseq_pkg::STAT_OFS: prdata_q <= {19'h00000, rate_active_q, lock_ok, done_eff,
                                          gsr_q, gts_q, gwe_q, state_q, phase_q};
        csseq_pkg::LOCKMASK_OFS: prdata_q <= {28'h0000000, lockmask_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Startup clock sources
  // ------------------------------------------------------------
  logic [6:0] osc_div;
  logic cfg_step;
  logic step;
  logic stall;
  csseq_tick_if osc_if ();
  csseq_tick_if cfg_if ();
  csseq_tick_if fab_if ();
  csseq_tick_if tck_if ();

  // Rate only changes once the image is in; until then the slowest after reset, the last loaded rate after a reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_active_q <= csseq_pkg::RATE_SLOWEST;
    end else if (load_pulse) begin
      rate_active_q <= opt_rate;
    end
  end

  always_comb begin
    case (rate_active_q)
      3'h1: osc_div = csseq_pkg::OSC_R1_DIV;
      3'h2: osc_div = csseq_pkg::OSC_R2_DIV;
      3'h3: osc_div = csseq_pkg::OSC_R3_DIV;
      3'h4: osc_div = csseq_pkg::OSC_R4_DIV;
      3'h5: osc_div = csseq_pkg::OSC_R5_DIV;
      default: osc_div = csseq_pkg::OSC_R0_DIV;
    endcase
  end

  csseq_osc_div u_osc (
    .pclk(pclk),
    .presetn(presetn),
    .div(osc_div),
    .osc(osc_if.src)
  );

  csseq_edge_det u_cfg_edge (
    .pclk(pclk),
    .presetn(presetn),
    .level(config_clock_in),
    .rise(cfg_if.src)
  );

  csseq_edge_det u_fab_edge (
    .pclk(pclk),
    .presetn(presetn),
    .level(fabric_clock_in),
    .rise(fab_if.src)
  );

  csseq_edge_det u_tck_edge (
    .pclk(pclk),
    .presetn(presetn),
    .level(tck_in),
    .rise(tck_if.src)
  );

  assign config_clock_tick = osc_if.tick;
  assign cfg_step = opt_extcfg ? cfg_if.tick : osc_if.tick;

  always_comb begin
    case (opt_clksel)
      csseq_pkg::CLKSEL_FAB: step = fab_if.tick;
      csseq_pkg::CLKSEL_TCK: step = tck_if.tick;
      default: step = cfg_step;
    endcase
  end

  // ------------------------------------------------------------
  // Completion input path and lock wait
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_pipe_q <= 1'b0;
    end else begin
      done_pipe_q <= done_in;
    end
  end

  // Pipelined path tolerates a slow rise on a shared chain pin
  assign done_eff = opt_pipe ? done_pipe_q : done_in;
  assign lock_ok = &(clock_manager_lock | ~lockmask_q);
  assign stall = (opt_lcksel != csseq_pkg::LCK_NO_LOCK_WAIT) && (phase_q == opt_lcksel)
                 && !lock_ok;

  // ------------------------------------------------------------
  // Phase sequencer
  // ------------------------------------------------------------
  logic advance;
  logic release_done;
  assign advance = (state_q == csseq_pkg::ST_STARTUP) && step && !stall
                   && (phase_q != csseq_pkg::PHASE_LAST);
  assign phase_d = phase_q + 3'h1;
  // Last phase waits for follow-mode releases before user mode
  assign release_done = gwe_q && !gts_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= csseq_pkg::ST_LOAD;
      phase_q <= 3'h0;
    end else if (reload_pulse) begin
      state_q <= csseq_pkg::ST_LOAD;
      phase_q <= 3'h0;
    end else if (state_q == csseq_pkg::ST_LOAD && load_pulse) begin
      state_q <= csseq_pkg::ST_STARTUP;
      phase_q <= 3'h0;
    end else if (advance) begin
      phase_q <= phase_d;
    end else if (state_q == csseq_pkg::ST_STARTUP && phase_q == csseq_pkg::PHASE_LAST
                 && release_done) begin
      state_q <= csseq_pkg::ST_USER;
    end
  end

  // Write-enable and tristate selections latched per load; keep code preserves the last one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gwe_sel_q <= csseq_pkg::GWESEL_RST;
      gts_sel_q <= csseq_pkg::GTSSEL_RST;
    end else if (state_q == csseq_pkg::ST_LOAD && load_pulse) begin
      if (opt_gwesel != csseq_pkg::SEL_KEEP) begin
        gwe_sel_q <= opt_gwesel;
      end
      if (opt_gtssel != csseq_pkg::SEL_KEEP) begin
        gts_sel_q <= opt_gtssel;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gsr_q <= 1'b1;
    end else if (reload_pulse || state_q == csseq_pkg::ST_LOAD) begin
      gsr_q <= 1'b1;
    end else if (advance && phase_q == 3'h0) begin
      gsr_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_act_q <= 1'b0;
    end else if (reload_pulse || state_q == csseq_pkg::ST_LOAD) begin
      done_act_q <= 1'b0;
    end else if (advance && phase_d == opt_donesel) begin
      done_act_q <= 1'b1;
    end
  end

  // Follow mode releases on a startup edge, so it lines up with the chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gwe_q <= 1'b0;
    end else if (reload_pulse || state_q == csseq_pkg::ST_LOAD) begin
      gwe_q <= 1'b0;
    end else if (gwe_sel_q == csseq_pkg::SEL_DONE) begin
      if (state_q == csseq_pkg::ST_STARTUP && step && done_eff) begin
        gwe_q <= 1'b1;
      end
    end else if (advance && phase_d == gwe_sel_q) begin
      gwe_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gts_q <= 1'b1;
    end else if (reload_pulse || state_q == csseq_pkg::ST_LOAD) begin
      gts_q <= 1'b1;
    end else if (gts_sel_q == csseq_pkg::SEL_DONE) begin
      if (state_q == csseq_pkg::ST_STARTUP && step && done_eff) begin
        gts_q <= 1'b0;
      end
    end else if (advance && phase_d == gts_sel_q) begin
      gts_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign global_write_enable = gwe_q;
  assign global_tristate = gts_q;
  assign global_set_reset = gsr_q;
  // Low until completion, then driven high or released to the pull-up
  assign done_out = done_act_q;
  assign done_oe = ~done_act_q | opt_drive;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_rate_load: assert property (load_pulse && state_q == csseq_pkg::ST_LOAD
    |=> rate_active_q == $past(opt_rate)) else $error("rate not taken at load");
  a_gsr_loading: assert property (state_q == csseq_pkg::ST_LOAD ##1 !reload_pulse
    |-> gsr_q) else $error("gsr low while loading");
  a_gsr_pulse: assert property ($fell(gsr_q) |-> $past(advance)
    && phase_q == 3'h1) else $error("gsr released off phase 1");
  a_phase_step: assert property (advance && !reload_pulse
    |=> phase_q == $past(phase_d)) else $error("phase did not advance");
  a_lock_stall: assert property (stall && !reload_pulse && !load_pulse
    |=> $stable(phase_q)) else $error("phase moved while lock wait");
  a_no_lock_wait_move: assert property (opt_lcksel == csseq_pkg::LCK_NO_LOCK_WAIT
    && state_q == csseq_pkg::ST_STARTUP && step && phase_q != csseq_pkg::PHASE_LAST
    && !reload_pulse |=> phase_q != $past(phase_q)) else $error("stalled w/o lock");
  a_done_phase: assert property ($rose(done_act_q) |-> phase_q == opt_donesel
    || $past(opt_q) != opt_q) else $error("completion in wrong phase");
  a_gwe_phase: assert property ($rose(gwe_q) && gwe_sel_q != csseq_pkg::SEL_DONE
    |-> phase_q == gwe_sel_q) else $error("write enable in wrong phase");
  a_gwe_follow: assert property ($rose(gwe_q) && gwe_sel_q == csseq_pkg::SEL_DONE
    |-> $past(done_eff) && $past(step)) else $error("write enable before done");
  a_gts_phase: assert property ($fell(gts_q) && gts_sel_q != csseq_pkg::SEL_DONE
    |-> phase_q == gts_sel_q) else $error("tristate freed in wrong phase");
  a_gts_follow: assert property ($fell(gts_q) && gts_sel_q == csseq_pkg::SEL_DONE
    |-> $past(done_eff)) else $error("tristate freed before done");
  a_done_float: assert property (done_act_q && !opt_drive |-> !done_oe)
    else $error("completion pin driven");
  a_pipe_stage: assert property (opt_pipe && $stable(opt_pipe)
    |-> done_eff == $past(done_in)) else $error("pipeline stage missing");

  c_user_mode: cover property (state_q == csseq_pkg::ST_STARTUP
    ##1 state_q == csseq_pkg::ST_USER);
  c_lock_wait: cover property (stall ##1 !stall);
  c_follow: cover property ($rose(gwe_q) && gwe_sel_q == csseq_pkg::SEL_DONE);
endmodule

// file: testbench/csseq_chain_peer.sv
`timescale 1ns/100ps
module csseq_chain_peer (
  input wire logic pclk,
  input wire logic [1:0] src,
  input wire logic go,
  input wire logic [3:0] hi_len,
  input wire logic hold_low,
  input wire logic done_out,
  input wire logic done_oe,
  output logic config_clock_in,
  output logic fabric_clock_in,
  output logic tck_in,
  output logic done_in
);
  // ----------------------------------------------------------
  // Startup clock pulses, still between steps
  // ----------------------------------------------------------
  int cnt = 0;
  logic lvl = 1'b0;
  always @(posedge pclk) begin
    if (go) begin
      lvl <= 1'b1;
      cnt <= int'(hi_len);
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      lvl <= 1'b0;
      cnt <= 0;
    end
  end
  assign config_clock_in = lvl & (src == 2'h0);
  assign fabric_clock_in = lvl & (src == 2'h1);
  assign tck_in = lvl & (src == 2'h2);
  // ----------------------------------------------------------
  // Shared completion wire
  // ----------------------------------------------------------
  // Pull-up when released; this member only ever holds it low
  assign done_in = done_oe ? done_out : ~hold_low;
endmodule

// file: testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go, hold_low, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic config_clock_in, fabric_clock_in, tck_in, done_in, done_out, done_oe;
  logic config_clock_tick, global_write_enable, global_tristate, global_set_reset;
  logic [3:0] clock_manager_lock, hi_len, m_mask;
  logic [1:0] src;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  int m_ph, m_st, m_we, m_ts, m_sr, m_done, m_wesel, m_tssel, m_rate, o_done, o_lck, o_drv;

  csseq_top csseq_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .config_clock_in(config_clock_in), .fabric_clock_in(fabric_clock_in),
    .tck_in(tck_in), .clock_manager_lock(clock_manager_lock), .done_in(done_in),
    .done_out(done_out), .done_oe(done_oe), .config_clock_tick(config_clock_tick),
    .global_write_enable(global_write_enable), .global_tristate(global_tristate),
    .global_set_reset(global_set_reset));
  csseq_chain_peer csseq_chain_peer_inst (.pclk(pclk), .src(src), .go(go), .hi_len(hi_len),
    .hold_low(hold_low), .done_out(done_out), .done_oe(done_oe),
    .config_clock_in(config_clock_in), .fabric_clock_in(fabric_clock_in), .tck_in(tck_in),
    .done_in(done_in));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ----------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------
  function automatic logic [31:0] opt(int rt, int ck, int ex, int ds, int we, int ts, int lk,
      int dr, int pp);
    return 32'(rt + (ck << 3) + (ex << 5) + (ds << 6) + (we << 9) + (ts << 12) + (lk << 15)
      + (dr << 18) + (pp << 19));
  endfunction

  function automatic logic locks_ok();
    return &(clock_manager_lock | ~m_mask);
  endfunction

  function automatic logic m_wire();
    if (m_done == 1 && o_drv == 0) return ~hold_low;
    return m_done == 1;
  endfunction

  function automatic logic [31:0] m_stat();
    return {19'h0, 3'(m_rate), locks_ok(), m_wire(), 1'(m_sr), 1'(m_ts), 1'(m_we),
      2'(m_st), 3'(m_ph)};
  endfunction

  task automatic m_reset();
    m_st = 0;
    m_ph = 0;
    m_we = 0;
    m_ts = 1;
    m_sr = 1;
    m_done = 0;
  endtask

  task automatic check_all();
    logic [31:0] msk;
    // Phase field is undefined in load state; state may move at phase 7
    msk = (m_st == 0) ? 32'h3f8 : ((m_ph == 7) ? 32'h1fe7 : 32'h1fff);
    apb(1'b0, csseq_pkg::STAT_OFS, 32'h0);
    chk_reg("status", m_stat() & msk, rd & msk);
    chk_bit("write enable", 1'(m_we), global_write_enable);
    chk_bit("tristate", 1'(m_ts), global_tristate);
    chk_bit("set reset", 1'(m_sr), global_set_reset);
    chk_bit("done enable", !(m_done == 1 && o_drv == 0), done_oe);
    if (done_oe === 1'b1) chk_bit("done level", 1'(m_done), done_out);
  endtask

  task automatic step();
    logic eff;
    eff = m_wire();
    @(posedge pclk);
    hi_len <= 4'($urandom_range(5, 1));
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (10) @(posedge pclk);
    if (m_st == 1) begin
      if (m_ph < 7 && !(m_ph == o_lck && !locks_ok())) begin
        m_ph++;
        if (m_ph == 1) m_sr = 0;
        if (m_ph == o_done) m_done = 1;
        if (m_ph == m_wesel) m_we = 1;
        if (m_ph == m_tssel) m_ts = 0;
      end
      if (eff && m_wesel == 0) m_we = 1;
      if (eff && m_tssel == 0) m_ts = 0;
      if (m_ph == 7 && m_we == 1 && m_ts == 0) m_st = 2;
    end
  endtask

  task automatic run(input logic [31:0] v, input logic [3:0] mask, input int n);
    apb(1'b1, csseq_pkg::CTRL_OFS, 32'h2);
    m_reset();
    apb(1'b1, csseq_pkg::OPT_OFS, v);
    apb(1'b0, csseq_pkg::OPT_OFS, 32'h0);
    chk_reg("options", v, rd);
    apb(1'b1, csseq_pkg::LOCKMASK_OFS, {28'h0, mask});
    m_mask = mask;
    o_done = int'(v[8:6]);
    o_lck = int'(v[17:15]);
    o_drv = int'(v[18]);
    src <= v[4:3];
    check_all();
    apb(1'b1, csseq_pkg::CTRL_OFS, 32'h1);
    m_st = 1;
    m_rate = int'(v[2:0]);
    if (v[11:9] != 3'h7) m_wesel = int'(v[11:9]);
    if (v[14:12] != 3'h7) m_tssel = int'(v[14:12]);
    repeat (n) begin
      step();
      check_all();
    end
  endtask

  task automatic fin();
    step();
    apb(1'b0, csseq_pkg::STAT_OFS, 32'h0);
    chk_reg("state", 32'(m_st) << 3, rd & 32'h18);
  endtask

  task automatic tick_gap(input int exp);
    int n;
    n = 0;
    // Skip one whole period so a rate change settles first
    repeat (2) begin
      @(posedge pclk iff config_clock_tick === 1'b1);
      @(posedge pclk);
    end
    while (config_clock_tick !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk_reg("osc period", 32'(exp), 32'(n + 1));
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    int d, w, t;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    go = 1'b0;
    hi_len = 4'h1;
    hold_low = 1'b0;
    src = 2'h0;
    clock_manager_lock = 4'h0;
    m_reset();
    m_wesel = 6;
    m_tssel = 5;
    m_rate = 0;
    m_mask = 4'h0;
    o_drv = 0;
    void'($urandom(32'h2ef634b6));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, csseq_pkg::OPT_OFS, 32'h0);
    chk_reg("option reset", 32'h0003_dd00, rd);
    apb(1'b0, csseq_pkg::LOCKMASK_OFS, 32'h0);
    chk_reg("lock mask reset", 32'h0, rd);
    check_all();
    apb(1'b1, 8'h10, 32'hffff_ffff);
    chk_bit("unmapped error", 1'b1, err);
    apb(1'b0, 8'h10, 32'h0);
    chk_reg("unmapped read", 32'h0, rd);
    tick_gap(int'(csseq_pkg::OSC_R0_DIV));
    clock_manager_lock <= 4'($urandom_range(14, 0));
    run(opt(0, 0, 1, 4, 6, 5, 7, 0, 0), 4'hf, 8);
    fin();
    d = $urandom_range(6, 1);
    w = $urandom_range(6, 1);
    t = $urandom_range(6, 1);
    run(opt(0, 1, 0, d, w, t, 7, 1, 0), 4'h0, 8);
    fin();
    run(opt(0, 2, 0, d, 7, 7, 7, 0, 0), 4'h0, 8);
    fin();
    hold_low <= 1'b1;
    run(opt(0, 1, 0, 3, 0, 0, 7, 0, 1), 4'h0, 9);
    hold_low <= 1'b0;
    repeat (3) @(posedge pclk);
    check_all();
    fin();
    check_all();
    clock_manager_lock <= 4'ha;
    run(opt(0, 1, 0, 4, 6, 5, 2, 0, 0), 4'h5, 5);
    clock_manager_lock <= 4'hf;
    repeat (6) begin
      step();
      check_all();
    end
    fin();
    run(opt(5, 0, 0, 4, 6, 5, 7, 0, 0), 4'h0, 0);
    tick_gap(int'(csseq_pkg::OSC_R5_DIV));
    repeat (20) begin
      apb(1'b0, csseq_pkg::STAT_OFS, 32'h0);
      if (rd[4:3] == 2'h2) break;
    end
    chk_reg("internal clock state", 32'h10, rd & 32'h18);
    chk_reg("active rate", 32'h5, (rd >> 10) & 32'h7);
    print_verdict();
  end
endmodule
